/* File: inc/spimsp_pkg.sv */
// package for the spi master/slave port: register map, fields, timing
package spimsp_pkg;
  // ----------------------------------------
  // register word offsets (byte addresses)
  // ----------------------------------------
  localparam logic [3:0] OFF_CONTROL = 4'h0;  // port_control
  localparam logic [3:0] OFF_STATUS  = 4'h4;  // port_status
  localparam logic [3:0] OFF_DIVIDER = 4'h8;  // serial_clock_divider
  localparam logic [3:0] OFF_TX      = 4'hc;  // transmit_holding / receive_holding
  // ----------------------------------------
  // control fields
  // ----------------------------------------
  localparam int CB_EN    = 0;
  localparam int CB_MAST  = 1;
  localparam int CB_CPHA  = 2;
  localparam int CB_CPOL  = 3;
  localparam int CB_LSBF  = 5;
  localparam int CB_TXMOD = 6;
  localparam int CB_UNDR  = 7;
  localparam int CB_OVWR  = 8;
  localparam int CB_SELEN = 9;
  localparam int CB_SOEN  = 10;
  localparam int CB_LOOP  = 11;
  localparam int CB_CONT  = 12;
  localparam logic [15:0] CTRL_MASK  = 16'h1fef;  // writable control bits
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [7:0]  DIV_RESET  = 8'h00;
  // ----------------------------------------
  // status fields
  // ----------------------------------------
  localparam int SB_TXFULL = 0;
  localparam int SB_TXIRQ  = 1;
  localparam int SB_TXUNDR = 2;
  localparam int SB_RXFULL = 3;
  localparam int SB_RXIRQ  = 4;
  localparam int SB_RXOVF  = 5;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam logic [2:0] BIT_LAST  = 3'h7;   // eight bits per byte
  localparam logic [3:0] STALL_CYC = 4'h8;   // idle cycles between single bytes
  // master engine states
  typedef enum logic [2:0] {
    SPIM_IDLE  = 3'b001,
    SPIM_SHIFT = 3'b010,
    SPIM_STALL = 3'b100
  } spimsp_state_t;
  // serial pin bundle toward the pads
  typedef struct packed {
    logic sclk;
    logic sclk_oe;
    logic mosi;
    logic mosi_oe;
    logic miso;
    logic miso_oe;
    logic cs_n;
    logic cs_oe;
  } spimsp_pins_t;
endpackage : spimsp_pkg

/* File: rtl/spimsp_port.sv */
// spi master/slave port with avalon-mm register slave
//
// The Avalon-MM interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
// Summary of operation
// - slave: chip select low frames byte transfers
// - continuous master shifts while transmit valid
// - continuous: select held until transmit empty
// - single byte mode stalls between bytes
// - loop-back ties output data to input
// - slave output driven only when enabled
// - select enable gates master select output
// - overwrite set: new byte replaces old
// - overwrite clear: new byte discarded
// - underflow resends previous byte or zero
// - transfer mode set: transmit write starts
// - transfer mode clear: receive read starts
// - bit 5 selects lsb first order
// - polarity bit sets clock idle level
// - phase bit places clock pulse in bit
// - bit1 master select, bit0 port enable
// - overflow flag set, cleared by receive read
// - receive full and irq cleared by read
// - underflow flag cleared by transmit write
// - transmit irq from empty or underflow
// - transmit full flag while byte pending
// - clock rate core over two(1+div)
// - drive one edge, sample the other
// - sclk output master, input slave; eight periods
module spimsp_port (
  // clock, reset, enable
  input  wire logic                 sys_clk_in,
  input  wire logic                 rst_in,
  input  wire logic                 clk_en_in,
  // avalon-mm slave
  input  wire logic [3:0]           avs_address_in,
  input  wire logic                 avs_read_in,
  input  wire logic                 avs_write_in,
  input  wire logic [31:0]          avs_writedata_in,
  output logic      [31:0]          avs_readdata_out,
  output logic                      avs_waitrequest_out,
  // serial pins (inputs from pads)
  input  wire logic                 sclk_in,
  input  wire logic                 mosi_in,
  input  wire logic                 miso_in,
  input  wire logic                 cs_n_in,
  // serial pins toward pads
  output spimsp_pkg::spimsp_pins_t  pins_out,
  // interrupt requests, level
  output logic                      tx_irq_out,
  output logic                      rx_irq_out
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [15:0] ctrl_reg;           // port_control
  logic [7:0]  div_reg;            // serial_clock_divider
  logic [7:0]  tx_reg;             // transmit_holding
  logic [7:0]  rx_reg;             // receive_holding
  logic [7:0]  prev_reg;           // last byte sent, for underflow resend
  logic        tx_full_reg;
  logic        tx_undr_reg;
  logic        rx_full_reg;
  logic        rx_ovf_reg;
  logic        tx_irq_reg;
  logic        ack_reg;            // one-cycle answer phase
  // shift engine
  spimsp_pkg::spimsp_state_t state_reg;
  logic [7:0]  sh_reg;             // shift register
  logic [2:0]  bit_reg;            // bit counter
  logic        half_reg;           // 0 = first half of bit, 1 = second
  logic [7:0]  dcnt_reg;           // divider counter
  logic [3:0]  stall_reg;
  logic        sclk_prev_reg;      // slave edge detect
  logic        cs_prev_reg;
  logic        s_din_reg;          // slave sampled bit
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // bit to shift out first for the chosen order
  function automatic logic out_bit(input logic [7:0] v, input logic lsbf);
    out_bit = lsbf ? v[0] : v[7];
  endfunction : out_bit
  // shift a new bit in according to order
  function automatic logic [7:0] shift_in(input logic [7:0] v, input logic lsbf,
                                          input logic b);
    shift_in = lsbf ? {b, v[7:1]} : {v[6:0], b};
  endfunction : shift_in

  wire logic en      = ctrl_reg[spimsp_pkg::CB_EN];
  wire logic master  = ctrl_reg[spimsp_pkg::CB_MAST];
  wire logic cpol    = ctrl_reg[spimsp_pkg::CB_CPOL];
  wire logic cpha    = ctrl_reg[spimsp_pkg::CB_CPHA];
  wire logic lsbf    = ctrl_reg[spimsp_pkg::CB_LSBF];
  wire logic sel_wr  = avs_address_in == spimsp_pkg::OFF_TX;
  wire logic req     = (avs_read_in | avs_write_in) & ~ack_reg;
  // writes land at the answer edge, where the master sees waitrequest low
  wire logic tx_wr   = ack_reg & avs_write_in & sel_wr & clk_en_in;
  wire logic rx_rd   = req & avs_read_in & sel_wr & clk_en_in;
  wire logic tick    = dcnt_reg == div_reg;
  // loop-back feeds our own output back as input data
  wire logic m_din   = ctrl_reg[spimsp_pkg::CB_LOOP] ? pins_out.mosi : miso_in;
  wire logic s_raw   = ctrl_reg[spimsp_pkg::CB_LOOP] ? pins_out.miso : mosi_in;
  wire logic cs_act  = ~cs_n_in & en & ~master;
  // slave active edges: sample on leading edge when cpha clear
  wire logic s_lead  = cs_act & cs_prev_reg & (sclk_in != sclk_prev_reg) & (sclk_in != cpol);
  wire logic s_trail = cs_act & cs_prev_reg & (sclk_in != sclk_prev_reg) & (sclk_in == cpol);
  wire logic s_samp  = cpha ? s_trail : s_lead;
  wire logic s_drive = cpha ? s_lead : s_trail;
  wire logic m_end   = state_reg == spimsp_pkg::SPIM_SHIFT & tick & half_reg
                       & bit_reg == spimsp_pkg::BIT_LAST;
  wire logic s_end   = s_samp & bit_reg == spimsp_pkg::BIT_LAST;
  wire logic byte_done = m_end | s_end;
  // slave: the last bit is on the pin now, not yet in the sampled flop
  wire logic [7:0] rx_byte = master ? shift_in(sh_reg, lsbf, m_din)
                                    : shift_in(sh_reg, lsbf, s_raw);
  // byte to load on start: pending data, or underflow fill
  wire logic [7:0] load_byte = tx_full_reg ? tx_reg :
                   (ctrl_reg[spimsp_pkg::CB_UNDR] ? prev_reg : 8'h00);
  // master start triggers
  wire logic m_start = state_reg == spimsp_pkg::SPIM_IDLE & en & master &
                       (ctrl_reg[spimsp_pkg::CB_TXMOD] ? tx_full_reg : rx_rd);

  // ----------------------------------------
  // avalon slave: one wait state per access
  // ----------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      ack_reg <= 1'b0;
    end else if (clk_en_in) begin
      ack_reg <= req;
    end
  end
  // waitrequest high until the answer cycle
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      avs_waitrequest_out <= 1'b1;
    end else if (clk_en_in) begin
      avs_waitrequest_out <= ~req;
    end
  end
  // read data mux, registered in the request cycle
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      avs_readdata_out <= 32'h0;
    end else if (clk_en_in && req && avs_read_in) begin
      unique case (avs_address_in)
        spimsp_pkg::OFF_CONTROL: avs_readdata_out <= {16'h0, ctrl_reg};
        spimsp_pkg::OFF_STATUS:  avs_readdata_out <= {24'h0, 2'b00, rx_ovf_reg,
                                   rx_full_reg | rx_ovf_reg, rx_full_reg,
                                   tx_undr_reg, tx_irq_reg, tx_full_reg};
        spimsp_pkg::OFF_DIVIDER: avs_readdata_out <= {24'h0, div_reg};
        spimsp_pkg::OFF_TX:      avs_readdata_out <= {24'h0, rx_reg};
        default:                 avs_readdata_out <= 32'h0;
      endcase
    end
  end
  // control and divider writes
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      ctrl_reg <= spimsp_pkg::CTRL_RESET;
      div_reg  <= spimsp_pkg::DIV_RESET;
    end else if (clk_en_in && ack_reg && avs_write_in) begin
      if (avs_address_in == spimsp_pkg::OFF_CONTROL) begin
        ctrl_reg <= avs_writedata_in[15:0] & spimsp_pkg::CTRL_MASK;
      end
      if (avs_address_in == spimsp_pkg::OFF_DIVIDER) begin
        div_reg <= avs_writedata_in[7:0];
      end
    end
  end

  // ----------------------------------------
  // transmit holding and flags
  // ----------------------------------------
  // a byte is taken into the shifter at master start, continuous reload, slave frame start or slave last-bit drive edge
  wire logic s_load = cs_act & ~cs_prev_reg;
  wire logic m_load = m_start | (state_reg == spimsp_pkg::SPIM_SHIFT & m_end &
                       ctrl_reg[spimsp_pkg::CB_CONT] & tx_full_reg);
  // slave reloads on the drive edge that closes the last bit, not mid-bit
  wire logic s_next = s_drive & cs_act & cs_prev_reg & bit_reg == spimsp_pkg::BIT_LAST;
  wire logic take = m_load | s_load | s_next;
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      tx_reg      <= 8'h00;
      prev_reg    <= 8'h00;
      tx_full_reg <= 1'b0;
      tx_undr_reg <= 1'b0;
    end else if (clk_en_in) begin
      if (take) begin
        prev_reg    <= load_byte;
        tx_full_reg <= 1'b0;
        if (!tx_full_reg) begin
          tx_undr_reg <= 1'b1;
        end
      end
      if (tx_wr) begin
        tx_reg      <= avs_writedata_in[7:0];
        tx_full_reg <= 1'b1;
        if (!take) begin
          tx_undr_reg <= 1'b0;
        end
      end
    end
  end
  // transmit irq: empty or underflow; cleared by write or disabled idle port
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      tx_irq_reg <= 1'b0;
    end else if (clk_en_in) begin
      if (!en && state_reg == spimsp_pkg::SPIM_IDLE) begin
        tx_irq_reg <= 1'b0;
      end else if (tx_wr) begin
        tx_irq_reg <= 1'b0;
      end else if (!tx_full_reg || tx_undr_reg) begin
        tx_irq_reg <= 1'b1;
      end
    end
  end
  // receive holding: overwrite or discard on overflow; set beats read-clear
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      rx_reg      <= 8'h00;
      rx_full_reg <= 1'b0;
      rx_ovf_reg  <= 1'b0;
    end else if (clk_en_in) begin
      if (rx_rd) begin
        rx_full_reg <= 1'b0;
        rx_ovf_reg  <= 1'b0;
      end
      if (byte_done) begin
        if (!rx_full_reg || rx_rd || ctrl_reg[spimsp_pkg::CB_OVWR]) begin
          rx_reg <= rx_byte;
        end
        rx_full_reg <= 1'b1;
        if (rx_full_reg && !rx_rd) begin
          rx_ovf_reg <= 1'b1;
        end
      end
    end
  end
  // irq outputs: master transmit mode uses tx irq, master receive mode uses rx irq; slave mode uses both
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      tx_irq_out <= 1'b0;
      rx_irq_out <= 1'b0;
    end else if (clk_en_in) begin
      tx_irq_out <= tx_irq_reg & (ctrl_reg[spimsp_pkg::CB_TXMOD] | ~master);
      rx_irq_out <= (rx_full_reg | rx_ovf_reg) &
                    (~ctrl_reg[spimsp_pkg::CB_TXMOD] | ~master);
    end
  end

  // ----------------------------------------
  // master engine
  // ----------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      state_reg <= spimsp_pkg::SPIM_IDLE;
      dcnt_reg  <= 8'h00;
      half_reg  <= 1'b0;
      stall_reg <= 4'h0;
    end else if (clk_en_in) begin
      dcnt_reg <= (tick || state_reg != spimsp_pkg::SPIM_SHIFT) ? 8'h00 : dcnt_reg + 8'h01;
      unique case (state_reg)
        spimsp_pkg::SPIM_IDLE: begin
          half_reg <= 1'b0;
          if (m_start) begin
            state_reg <= spimsp_pkg::SPIM_SHIFT;
          end
        end
        spimsp_pkg::SPIM_SHIFT: begin
          if (tick) begin
            half_reg <= ~half_reg;
          end
          if (!en || !master) begin
            state_reg <= spimsp_pkg::SPIM_IDLE;
          end else if (m_end) begin
            if (ctrl_reg[spimsp_pkg::CB_CONT] && tx_full_reg) begin
              state_reg <= spimsp_pkg::SPIM_SHIFT;
            end else if (ctrl_reg[spimsp_pkg::CB_CONT]) begin
              state_reg <= spimsp_pkg::SPIM_IDLE;
            end else begin
              state_reg <= spimsp_pkg::SPIM_STALL;
              stall_reg <= spimsp_pkg::STALL_CYC;
            end
          end
        end
        spimsp_pkg::SPIM_STALL: begin
          stall_reg <= stall_reg - 4'h1;
          if (stall_reg == 4'h1) begin
            state_reg <= spimsp_pkg::SPIM_IDLE;
          end
        end
      endcase
    end
  end
  // shifter and bit counter, shared by both modes
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      sh_reg        <= 8'h00;
      bit_reg       <= 3'h0;
      sclk_prev_reg <= 1'b0;
      cs_prev_reg   <= 1'b0;
      s_din_reg     <= 1'b0;
    end else if (clk_en_in) begin
      sclk_prev_reg <= sclk_in;
      cs_prev_reg   <= cs_act;
      if (take) begin
        sh_reg  <= load_byte;
        bit_reg <= 3'h0;
      end else if (master && state_reg == spimsp_pkg::SPIM_SHIFT && tick) begin
        if (half_reg) begin
          sh_reg  <= shift_in(sh_reg, lsbf, m_din);
          bit_reg <= bit_reg + 3'h1;
        end
      end else if (!master) begin
        if (!cs_act) begin
          bit_reg <= 3'h0;
        end else if (s_samp) begin
          s_din_reg <= s_raw;
        end
        if (s_drive && cs_act && cs_prev_reg) begin
          sh_reg  <= shift_in(sh_reg, lsbf, s_din_reg);
          bit_reg <= bit_reg + 3'h1;
        end
      end
    end
  end
  // pad outputs, all registered
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      pins_out <= '0;
      pins_out.cs_n <= 1'b1;
    end else if (clk_en_in) begin
      // clock toggles mid-bit when phase clear, at bit start when set
      pins_out.sclk    <= cpol ^ (state_reg == spimsp_pkg::SPIM_SHIFT &
                          (half_reg ^ cpha));
      pins_out.sclk_oe <= en & master;
      pins_out.mosi    <= out_bit(sh_reg, lsbf);
      pins_out.mosi_oe <= en & master;
      pins_out.miso    <= out_bit(sh_reg, lsbf);
      pins_out.miso_oe <= cs_act & ctrl_reg[spimsp_pkg::CB_SOEN];
      pins_out.cs_n    <= ~(state_reg == spimsp_pkg::SPIM_SHIFT);
      pins_out.cs_oe   <= en & master & ctrl_reg[spimsp_pkg::CB_SELEN];
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_cs_master;
    @(posedge sys_clk_in) disable iff (rst_in)
      clk_en_in && state_reg == spimsp_pkg::SPIM_SHIFT |=> !pins_out.cs_n;
  endproperty
  a_cs_master: assert property (p_cs_master) else $error("select not active");
  property p_stall;
    @(posedge sys_clk_in) disable iff (rst_in)
      $rose(state_reg == spimsp_pkg::SPIM_STALL) |=> state_reg == spimsp_pkg::SPIM_STALL;
  endproperty
  a_stall: assert property (p_stall) else $error("stall skipped");
  property p_soe;
    @(posedge sys_clk_in) disable iff (rst_in)
      !ctrl_reg[spimsp_pkg::CB_SOEN] && clk_en_in |=> !pins_out.miso_oe;
  endproperty
  a_soe: assert property (p_soe) else $error("slave output driven");
  property p_txwr;
    @(posedge sys_clk_in) disable iff (rst_in)
      tx_wr && !take |=> tx_full_reg && !tx_undr_reg;
  endproperty
  a_txwr: assert property (p_txwr) else $error("tx write flags");
  property p_rxrd;
    @(posedge sys_clk_in) disable iff (rst_in)
      rx_rd && !byte_done |=> !rx_full_reg && !rx_ovf_reg;
  endproperty
  a_rxrd: assert property (p_rxrd) else $error("rx read clear");
  property p_keep;
    @(posedge sys_clk_in) disable iff (rst_in)
      byte_done && rx_full_reg && !rx_rd && !ctrl_reg[spimsp_pkg::CB_OVWR] && clk_en_in
      |=> rx_reg == $past(rx_reg);
  endproperty
  a_keep: assert property (p_keep) else $error("old byte lost");
  property p_idle_clk;
    @(posedge sys_clk_in) disable iff (rst_in)
      state_reg == spimsp_pkg::SPIM_IDLE && $past(state_reg == spimsp_pkg::SPIM_IDLE)
      && clk_en_in |=> pins_out.sclk == $past(cpol);
  endproperty
  a_idle_clk: assert property (p_idle_clk) else $error("clock idle level");
  property p_rsv;
    @(posedge sys_clk_in) disable iff (rst_in) (ctrl_reg & ~spimsp_pkg::CTRL_MASK) == 16'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit set");
  c_master: cover property (@(posedge sys_clk_in) m_end);
  c_slave: cover property (@(posedge sys_clk_in) s_end);
  c_ovf: cover property (@(posedge sys_clk_in) byte_done && rx_full_reg);
endmodule : spimsp_port

/* File: verification/spimsp_slave_model.sv */
// behavioural external spi slave that faces the port's master side
`timescale 1ns/1ps
module spimsp_slave_model (
  // serial side
  input  wire logic       sclk_in,
  input  wire logic       cs_n_in,
  input  wire logic       mosi_in,
  output logic            miso_out,
  // bench side
  input  wire logic [7:0] resp_in,
  output logic [7:0]      got_out,
  output logic [3:0]      edges_out
);
  logic [7:0] tx_sh;  // answer shifter
  // ----------------------------------------
  // frame start: load answer, restart count
  // ----------------------------------------
  always @(negedge cs_n_in) begin
    tx_sh = resp_in;
    edges_out = 4'h0;
    miso_out = resp_in[7];
  end
  // ----------------------------------------
  // idle-low clock, phase clear only: sample on rise, shift on fall
  // ----------------------------------------
  always @(sclk_in) begin
    if (cs_n_in === 1'b0) begin
      if (sclk_in) begin
        got_out = {got_out[6:0], mosi_in};
        edges_out = edges_out + 4'h1;
      end else begin
        tx_sh = {tx_sh[6:0], 1'b0};
        miso_out = tx_sh[7];
      end
    end
  end
  // released line shows the inverse, so a stale bit never passes
  always @(posedge cs_n_in) miso_out = ~miso_out;
endmodule : spimsp_slave_model

/* File: verification/test_spi_master_slave_port.sv */
// self-checking bench for the spi master/slave port
`timescale 1ns/1ps
module test_spi_master_slave_port;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam logic [3:0] A_C = spimsp_pkg::OFF_CONTROL;
  localparam logic [3:0] A_S = spimsp_pkg::OFF_STATUS;
  localparam logic [3:0] A_D = spimsp_pkg::OFF_DIVIDER;
  localparam logic [3:0] A_T = spimsp_pkg::OFF_TX;
  logic                     sys_clk_in, rst_in, rd, wr, wait_rq, tx_irq, rx_irq, miso, sclk_q;
  logic [3:0]               addr, edges;
  logic [31:0]              wdata, rdata;
  spimsp_pkg::spimsp_pins_t pins;
  logic [7:0]               resp, got, b;
  logic                     s_sclk, s_mosi, s_cs_n;  // external master pins
  logic [15:0]              s, per, cnt;
  int                       errors, checked, cyc;
  // ----------------------------------------
  // design and far-side slave
  // ----------------------------------------
  spimsp_port dut_u (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .clk_en_in(1'b1),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wait_rq), .sclk_in(s_sclk),
    .mosi_in(s_mosi), .miso_in(miso), .cs_n_in(s_cs_n), .pins_out(pins),
    .tx_irq_out(tx_irq), .rx_irq_out(rx_irq));
  spimsp_slave_model slave_u (.sclk_in(pins.sclk), .cs_n_in(pins.cs_n), .mosi_in(pins.mosi),
    .miso_out(miso), .resp_in(resp), .got_out(got), .edges_out(edges));
  // clock, 100 ns period
  initial begin
    sys_clk_in = 1'b0;
    forever #50 sys_clk_in = ~sys_clk_in;
  end
  // sclk period in core clocks, plus the hang guard
  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    sclk_q <= pins.sclk;
    cnt <= (pins.sclk && !sclk_q) ? 16'h1 : cnt + 16'h1;
    if (pins.sclk && !sclk_q) begin
      per <= cnt;
    end
    if (cyc == 20000) begin
      errors++;
      close_out();
    end
  end
  // ----------------------------------------
  // bus tasks: hold request until waitrequest sampled low
  // ----------------------------------------
  task automatic av_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk_in);
    addr <= a;
    wdata <= {16'h0000, d};
    wr <= 1'b1;
    @(posedge sys_clk_in);
    while (wait_rq !== 1'b0) @(posedge sys_clk_in);
    wr <= 1'b0;
  endtask : av_wr
  task automatic av_rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge sys_clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk_in);
    while (wait_rq !== 1'b0) @(posedge sys_clk_in);
    d = rdata[15:0];
    rd <= 1'b0;
  endtask : av_rd
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  // wait for a select frame to open and close, bounded
  task automatic wait_done();
    int n;
    n = 0;
    while (pins.cs_n !== 1'b0 && n < 60) begin
      @(posedge sys_clk_in);
      n++;
    end
    while (pins.cs_n !== 1'b1 && n < 900) begin
      @(posedge sys_clk_in);
      n++;
    end
    chk({15'h0, n < 900}, 16'h1);
  endtask : wait_done
  task automatic xfer(input logic [15:0] ctl, input logic [7:0] tx, input logic [7:0] r);
    resp = r;
    av_wr(A_C, ctl);
    av_wr(A_T, {8'h00, tx});
    wait_done();
  endtask : xfer
  // external master frame, idle-low clock, phase clear; collects slave output
  task automatic sframe(input logic [7:0] m, output logic [7:0] o);
    s_cs_n <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
    for (int i = 7; i >= 0; i--) begin
      s_mosi <= m[i];
      repeat (3) @(posedge sys_clk_in);
      o[i] = pins.miso;
      s_sclk <= 1'b1;
      repeat (3) @(posedge sys_clk_in);
      s_sclk <= 1'b0;
    end
    repeat (3) @(posedge sys_clk_in);
    s_cs_n <= 1'b1;
  endtask : sframe
  task automatic close_out();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out
  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    rst_in = 1'b1;
    addr = 4'h0;
    rd = 1'b0;
    wr = 1'b0;
    wdata = 32'h0;
    resp = 8'h00;
    errors = 0;
    checked = 0;
    cyc = 0;
    cnt = 16'h0;
    per = 16'h0;
    sclk_q = 1'b0;
    s_sclk = 1'b0;
    s_mosi = 1'b0;
    s_cs_n = 1'b1;
    repeat (8) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    av_rd(A_C, s);
    chk(s, 16'h0000);
    av_wr(A_C, 16'hffff);
    av_rd(A_C, s);
    chk(s, 16'h1fef);
    av_rd(A_S, s);
    chk(s & 16'hffc0, 16'h0000);
    av_wr(A_D, 16'h0002);
    av_rd(A_D, s);
    chk(s, 16'h0002);
    av_wr(A_C, 16'h020b);
    chk({15'h0, pins.sclk}, 16'h1);
    // plain msb-first byte started by a transmit write
    xfer(16'h0243, 8'h5a, 8'h3c);
    chk({15'h0, pins.sclk}, 16'h0);
    chk({8'h00, got}, 16'h005a);
    chk({12'h0, edges}, 16'h0008);
    chk(per, 16'h0006);
    av_rd(A_S, s);
    chk(s & 16'h0039, 16'h0018);
    av_rd(A_T, s);
    chk(s, 16'h003c);
    av_rd(A_S, s);
    chk(s & 16'h0038, 16'h0000);
    // lsb first both ways
    xfer(16'h0263, 8'h12, 8'h35);
    chk({8'h00, got}, 16'h0048);
    av_rd(A_T, s);
    chk(s, 16'h00ac);
    // receive overflow, discard then overwrite
    for (int ow = 0; ow < 2; ow++) begin
      xfer(ow ? 16'h0343 : 16'h0243, 8'h11, 8'ha1);
      xfer(ow ? 16'h0343 : 16'h0243, 8'h22, 8'hb2);
      av_rd(A_S, s);
      chk(s & 16'h0038, 16'h0038);
      av_rd(A_T, s);
      chk(s, ow ? 16'h00b2 : 16'h00a1);
      av_rd(A_S, s);
      chk(s & 16'h0038, 16'h0000);
    end
    // loop-back ignores the far side
    xfer(16'h0a43, 8'h96, 8'h00);
    av_rd(A_T, s);
    chk(s, 16'h0096);
    // slave frame from an external master
    av_wr(A_C, 16'h0401);
    av_wr(A_T, 16'h00c5);
    sframe(8'h6b, b);
    chk({8'h00, b}, 16'h00c5);
    chk({15'h0, rx_irq}, 16'h1);
    av_rd(A_T, s);
    chk(s, 16'h006b);
    // receive-read start with an empty transmitter sends zero
    resp = 8'h77;
    av_wr(A_C, 16'h0203);
    av_rd(A_T, s);
    wait_done();
    chk({15'h0, rx_irq}, 16'h1);
    chk({8'h00, got}, 16'h0000);
    av_rd(A_S, s);
    chk(s & 16'h0004, 16'h0004);
    av_wr(A_T, 16'h0055);
    av_rd(A_S, s);
    chk(s & 16'h0004, 16'h0000);
    av_rd(A_T, s);
    chk(s, 16'h0077);
    close_out();
  end
endmodule : test_spi_master_slave_port
